// *** design/hs_i2c_slave.sv ***
// device end: hs entry/exit, alert response, pin-strapped address
`timescale 1ns/1ps
`include "hs_i2c_consts.svh"
module hs_i2c_slave #(
	parameter int TIMEOUT_CYC = `TIMEOUT_CYC,
	parameter int FS_FILT = `FS_FILT_CYC,
	parameter int HS_FILT = `HS_FILT_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_addr_select_low_pin,
	input wire logic i_addr_select_high_pin,
	input wire logic i_alert_pending,
	output logic o_hs_mode,
	output logic [6:0] o_own_addr,
	output logic o_ara_won,
	output logic o_timeout,
	hs_i2c_bus_if.slave bus
);
	localparam int TW = $clog2(TIMEOUT_CYC + 1);
	hs_i2c_pkg::slv_state_t state_ff, nxt_state;
	// line order: 0 scl, 1 sda, 2 low pin, 3 high pin
	logic [3:0] s1_ff, s2_ff, filt_ff, nxt_filt;
	logic [3:0] fcnt_ff [4];
	logic [3:0] nxt_fcnt [4];
	logic [1:0] prev_ff;
	logic [3:0] bit_ff, nxt_bit;
	logic [7:0] shreg_ff, nxt_shreg, tx_ff, nxt_tx;
	logic sda_oe_ff, nxt_sda_oe, hs_ff, nxt_hs, ara_ff, nxt_ara;
	logic [1:0] lo_ff, nxt_lo, hi_ff, nxt_hi, dsda_ff, nxt_dsda;
	logic [6:0] own_ff, nxt_own, cur_addr;
	logic [TW-1:0] to_ff, nxt_to;
	logic won_ff, nxt_won, tout_ff, nxt_tout, alert_ff;
	logic scl, sda, rise, fall, start, stop;
	localparam hs_i2c_pkg::slv_state_t S_IDLE = hs_i2c_pkg::S_IDLE;
	localparam hs_i2c_pkg::slv_state_t S_ADDR = hs_i2c_pkg::S_ADDR;
	localparam hs_i2c_pkg::slv_state_t S_ACK = hs_i2c_pkg::S_ACK;
	localparam hs_i2c_pkg::slv_state_t S_TX = hs_i2c_pkg::S_TX;
	localparam hs_i2c_pkg::slv_state_t S_TXACK = hs_i2c_pkg::S_TXACK;
	localparam hs_i2c_pkg::slv_state_t S_RX = hs_i2c_pkg::S_RX;
	localparam hs_i2c_pkg::slv_state_t S_WAIT = hs_i2c_pkg::S_WAIT;

	function automatic logic [1:0] sel_decode(input logic lo, input logic hi, input logic ds);
		if (!hi)
			sel_decode = hs_i2c_pkg::SEL_GND;
		else if (!lo)
			sel_decode = hs_i2c_pkg::SEL_VS;
		else if (!ds)
			sel_decode = hs_i2c_pkg::SEL_SDA;
		else
			sel_decode = hs_i2c_pkg::SEL_SCL;
	endfunction

	// ======================================
	// input filters
	always_comb
	begin
		nxt_filt = filt_ff;
		for (int i = 0; i < 4; i++)
		begin
			nxt_fcnt[i] = 4'h0;
			if (s2_ff[i] != filt_ff[i])
			begin
				nxt_fcnt[i] = fcnt_ff[i] + 4'h1;
				// hs filter only while hs is active
				if (fcnt_ff[i] >= 4'((hs_ff ? HS_FILT : FS_FILT) - 1))
				begin
					nxt_filt[i] = s2_ff[i];
					nxt_fcnt[i] = 4'h0;
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s1_ff <= 4'hf;
			s2_ff <= 4'hf;
			filt_ff <= 4'hf;
			prev_ff <= 2'h3;
			for (int i = 0; i < 4; i++)
				fcnt_ff[i] <= 4'h0;
		end
		else
		begin
			s1_ff <= {i_addr_select_high_pin, i_addr_select_low_pin, bus.sda, bus.scl};
			s2_ff <= s1_ff;
			filt_ff <= nxt_filt;
			prev_ff <= filt_ff[1:0];
			for (int i = 0; i < 4; i++)
				fcnt_ff[i] <= nxt_fcnt[i];
		end
	end

	// ======================================
	// protocol engine
	always_comb
	begin
		scl = filt_ff[0];
		sda = filt_ff[1];
		rise = scl && !prev_ff[0];
		fall = !scl && prev_ff[0];
		start = scl && prev_ff[0] && prev_ff[1] && !sda;
		stop = scl && prev_ff[0] && !prev_ff[1] && sda;
		// address from pin straps of this transfer
		cur_addr = {`SLV_ADDR_TOP, sel_decode(lo_ff[1], hi_ff[1], dsda_ff[1]),
			sel_decode(lo_ff[0], hi_ff[0], dsda_ff[0])};
		nxt_state = state_ff;
		nxt_bit = bit_ff;
		nxt_shreg = shreg_ff;
		nxt_tx = tx_ff;
		nxt_sda_oe = sda_oe_ff;
		nxt_hs = hs_ff;
		nxt_ara = ara_ff;
		nxt_lo = lo_ff;
		nxt_hi = hi_ff;
		nxt_dsda = dsda_ff;
		nxt_own = own_ff;
		nxt_won = 1'b0;
		nxt_tout = 1'b0;
		nxt_to = (state_ff == S_IDLE || rise || fall) ? '0 : to_ff + 1'b1;
		if (stop)
		begin
			nxt_state = S_IDLE;
			nxt_sda_oe = 1'b0;
			nxt_hs = 1'b0;
		end
		else if (start)
		begin
			// repeated start keeps hs
			nxt_state = S_ADDR;
			nxt_bit = 4'h0;
			nxt_sda_oe = 1'b0;
			nxt_lo = 2'h0;
			nxt_hi = 2'h0;
			nxt_dsda = 2'h0;
		end
		else if (to_ff == TW'(TIMEOUT_CYC - 1))
		begin
			nxt_state = S_IDLE;
			nxt_sda_oe = 1'b0;
			nxt_tout = 1'b1;
		end
		else
		begin
			case (state_ff)
				S_ADDR:
				begin
					nxt_lo = lo_ff | ~filt_ff[3:2];
					nxt_hi = hi_ff | filt_ff[3:2];
					nxt_dsda = dsda_ff | (filt_ff[3:2] ^ {sda, sda});
					if (rise)
					begin
						nxt_shreg = {shreg_ff[6:0], sda};
						nxt_bit = bit_ff + 4'h1;
					end
					if (fall && bit_ff == 4'h8)
					begin
						nxt_state = S_WAIT;
						if (shreg_ff[7:3] == `HS_CODE_TOP)
							nxt_hs = 1'b1; // no ack
						else if (shreg_ff == {`ARA_ADDR, 1'b1})
						begin
							nxt_ara = 1'b1;
							if (alert_ff)
							begin
								nxt_own = cur_addr;
								nxt_tx = {cur_addr, 1'b0};
								nxt_sda_oe = 1'b1;
								nxt_state = S_ACK;
							end
						end
						else if (shreg_ff[7:1] == cur_addr)
						begin
							nxt_ara = 1'b0;
							nxt_own = cur_addr;
							nxt_tx = 8'hff;
							nxt_sda_oe = 1'b1;
							nxt_state = S_ACK;
						end
					end
				end
				S_ACK:
					if (fall)
					begin
						nxt_bit = 4'h0;
						nxt_state = shreg_ff[0] ? S_TX : S_RX;
						nxt_sda_oe = shreg_ff[0] & ~tx_ff[7];
					end
				S_TX:
				begin
					if (rise)
					begin
						nxt_bit = bit_ff + 4'h1;
						// released for a one but line is low: lost
						if (!sda_oe_ff && !sda)
							nxt_state = S_WAIT;
					end
					if (fall)
					begin
						nxt_tx = {tx_ff[6:0], 1'b1};
						nxt_sda_oe = ~tx_ff[6];
						if (bit_ff == 4'h8)
						begin
							nxt_sda_oe = 1'b0;
							nxt_bit = 4'h0;
							nxt_state = S_TXACK;
						end
					end
				end
				S_TXACK:
				begin
					if (rise)
					begin
						nxt_won = ara_ff;
						if (ara_ff || sda)
							nxt_state = S_WAIT;
						else
							nxt_bit = 4'h1;
					end
					if (fall && bit_ff == 4'h1)
					begin
						nxt_tx = 8'hff;
						nxt_bit = 4'h0;
						nxt_sda_oe = 1'b0;
						nxt_state = S_TX;
					end
				end
				S_RX:
				begin
					if (rise)
						nxt_bit = bit_ff + 4'h1;
					if (fall && bit_ff == 4'h8)
					begin
						nxt_sda_oe = 1'b1;
						nxt_state = S_ACK;
					end
				end
				S_IDLE, S_WAIT:
					nxt_sda_oe = 1'b0;
				default:
					nxt_state = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_ff <= hs_i2c_pkg::S_IDLE;
			bit_ff <= 4'h0;
			shreg_ff <= 8'h00;
			tx_ff <= 8'hff;
			sda_oe_ff <= 1'b0;
			hs_ff <= 1'b0;
			ara_ff <= 1'b0;
			lo_ff <= 2'h0;
			hi_ff <= 2'h0;
			dsda_ff <= 2'h0;
			own_ff <= {`SLV_ADDR_TOP, 4'h0};
			to_ff <= '0;
			won_ff <= 1'b0;
			tout_ff <= 1'b0;
			alert_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			bit_ff <= nxt_bit;
			shreg_ff <= nxt_shreg;
			tx_ff <= nxt_tx;
			sda_oe_ff <= nxt_sda_oe;
			hs_ff <= nxt_hs;
			ara_ff <= nxt_ara;
			lo_ff <= nxt_lo;
			hi_ff <= nxt_hi;
			dsda_ff <= nxt_dsda;
			own_ff <= nxt_own;
			to_ff <= nxt_to;
			won_ff <= nxt_won;
			tout_ff <= nxt_tout;
			alert_ff <= i_alert_pending; // held low while pending
		end
	end

	assign o_hs_mode = hs_ff;
	assign o_own_addr = own_ff;
	assign o_ara_won = won_ff;
	assign o_timeout = tout_ff;
	assign bus.s_sda_out = 1'b0;
	assign bus.s_sda_oe = sda_oe_ff;
	assign bus.s_alert_out = 1'b0;
	assign bus.s_alert_oe = alert_ff;
endmodule // hs_i2c_slave

// *** design/hs_i2c_consts.svh ***
// constants shared by both ends of the high-speed i2c / alert link
`ifndef HS_I2C_CONSTS_SVH
`define HS_I2C_CONSTS_SVH
// upper five bits of the high-speed master code
`define HS_CODE_TOP 5'h01
// alert response address
`define ARA_ADDR 7'h0c
// upper three bits of the device address, low four from the select pins
`define SLV_ADDR_TOP 3'h4
`define CLK_PERIOD_NS 8
`define TIMEOUT_MS 28
`define TIMEOUT_CYC (`TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)
`define FS_SCL_KHZ 400
`define HS_SCL_KHZ 3400
`define FS_HALF_CYC ((1000000 / (2 * `FS_SCL_KHZ) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HS_HALF_CYC ((1000000 / (2 * `HS_SCL_KHZ) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FS_SPIKE_NS 50
`define HS_SPIKE_NS 10
`define FS_FILT_CYC ((`FS_SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HS_FILT_CYC ((`HS_SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** design/hs_i2c_pkg.sv ***
// types shared by both ends of the high-speed i2c / alert link
package hs_i2c_pkg;
	typedef enum {S_IDLE, S_ADDR, S_ACK, S_TX, S_TXACK, S_RX, S_WAIT} slv_state_t;
	typedef enum {M_IDLE, M_RS1, M_RS2, M_START, M_LO, M_HI, M_HOLD, M_STP1, M_STP2,
		M_STP3} mst_state_t;
	typedef enum logic [1:0] {SEL_GND, SEL_VS, SEL_SDA, SEL_SCL} sel_code_t;
endpackage

// *** design/hs_i2c_bus_if.sv ***
// open-drain scl, sda and alert wires between master and slave
`timescale 1ns/1ps
interface hs_i2c_bus_if;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic s_sda_out;
	logic s_sda_oe;
	logic s_alert_out;
	logic s_alert_oe;
	logic scl;
	logic sda;
	logic alert_n;
	// wired-and with pull-ups
	assign scl = ~m_scl_oe;
	assign sda = ~(m_sda_oe | s_sda_oe);
	assign alert_n = ~s_alert_oe;
	modport master (input scl, input sda, input alert_n, output m_scl_out, output m_scl_oe,
		output m_sda_out, output m_sda_oe);
	modport slave (input scl, input sda, output s_sda_out, output s_sda_oe,
		output s_alert_out, output s_alert_oe);
endinterface

// *** design/hs_i2c_master.sv ***
// bus master end: start, byte, optional read byte, stop or hold
`timescale 1ns/1ps
`include "hs_i2c_consts.svh"
// Summary of operation
// - master sends code 00001xxx after start
// - code byte sent at 400 kHz or less
// - code not acked, filters switch to hs
// - repeated start, then normal protocol, faster
// - master keeps hs with repeated starts
// - stop returns filters to f/s setting
// - alert response address read is recognised
// - pending alert: ack, send own address
// - arbitrate while sending, loser releases sda and waits for stop
// - loser keeps alert low until cleared
// - address comes from two select pins
// - pins sampled each transfer, 16 addresses
// - 28 ms timeout frees a stalled bus
module hs_i2c_master #(
	parameter int FS_HALF = `FS_HALF_CYC,
	parameter int HS_HALF = `HS_HALF_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_cmd_valid,
	input wire logic [7:0] i_cmd_byte,
	input wire logic i_cmd_read,
	input wire logic i_cmd_stop,
	output logic o_cmd_ready,
	output logic o_done,
	output logic o_acked,
	output logic [7:0] o_rdata,
	output logic o_hs_mode,
	hs_i2c_bus_if.master bus
);
	hs_i2c_pkg::mst_state_t state_ff, nxt_state;
	logic [1:0] s1_ff, s2_ff;
	logic [7:0] div_ff, nxt_div;
	logic [4:0] bit_ff, nxt_bit;
	logic [7:0] byte_ff, nxt_byte, rdata_ff, nxt_rdata;
	logic read_ff, nxt_read, stop_ff, nxt_stop, hs_ff, nxt_hs;
	logic scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
	logic done_ff, nxt_done, acked_ff, nxt_acked, ready_ff, nxt_ready;
	logic tick;
	localparam hs_i2c_pkg::mst_state_t M_IDLE = hs_i2c_pkg::M_IDLE;
	localparam hs_i2c_pkg::mst_state_t M_RS1 = hs_i2c_pkg::M_RS1;
	localparam hs_i2c_pkg::mst_state_t M_RS2 = hs_i2c_pkg::M_RS2;
	localparam hs_i2c_pkg::mst_state_t M_START = hs_i2c_pkg::M_START;
	localparam hs_i2c_pkg::mst_state_t M_LO = hs_i2c_pkg::M_LO;
	localparam hs_i2c_pkg::mst_state_t M_HI = hs_i2c_pkg::M_HI;
	localparam hs_i2c_pkg::mst_state_t M_HOLD = hs_i2c_pkg::M_HOLD;
	localparam hs_i2c_pkg::mst_state_t M_STP1 = hs_i2c_pkg::M_STP1;
	localparam hs_i2c_pkg::mst_state_t M_STP2 = hs_i2c_pkg::M_STP2;
	localparam hs_i2c_pkg::mst_state_t M_STP3 = hs_i2c_pkg::M_STP3;

	function automatic logic drv_bit(input logic [4:0] b, input logic [7:0] d);
		drv_bit = (b < 5'h08) ? ~d[3'h7 - b[2:0]] : 1'b0;
	endfunction

	// ======================================
	// bit sequencer
	always_comb
	begin
		nxt_state = state_ff;
		nxt_bit = bit_ff;
		nxt_byte = byte_ff;
		nxt_read = read_ff;
		nxt_stop = stop_ff;
		nxt_hs = hs_ff;
		nxt_scl_oe = scl_oe_ff;
		nxt_sda_oe = sda_oe_ff;
		nxt_done = 1'b0;
		nxt_acked = acked_ff;
		nxt_rdata = rdata_ff;
		// hs rate only after the code byte went out at f/s rate
		tick = div_ff == 8'((hs_ff ? HS_HALF : FS_HALF) - 1);
		nxt_div = tick ? 8'h00 : div_ff + 8'h01;
		case (state_ff)
			M_IDLE, M_HOLD:
			begin
				nxt_div = 8'h00;
				if (state_ff == M_HOLD)
					nxt_sda_oe = 1'b0;
				if (i_cmd_valid && ready_ff)
				begin
					nxt_byte = i_cmd_byte;
					nxt_read = i_cmd_read;
					nxt_stop = i_cmd_stop;
					// a held bus gets a repeated start
					nxt_state = (state_ff == M_HOLD) ? M_RS1 : M_START;
				end
			end
			M_RS1:
				if (tick)
				begin
					nxt_scl_oe = 1'b0;
					nxt_state = M_RS2;
				end
			M_RS2:
				if (tick)
				begin
					nxt_sda_oe = 1'b1;
					nxt_state = M_START;
				end
			M_START:
			begin
				nxt_sda_oe = 1'b1;
				if (tick)
				begin
					nxt_scl_oe = 1'b1;
					nxt_bit = 5'h00;
					nxt_state = M_LO;
				end
			end
			M_LO:
			begin
				nxt_sda_oe = drv_bit(bit_ff, byte_ff);
				if (tick)
				begin
					nxt_scl_oe = 1'b0;
					nxt_state = M_HI;
				end
			end
			M_HI:
			begin
				if (!s2_ff[0])
					nxt_div = 8'h00;
				if (tick)
				begin
					if (bit_ff == 5'h08)
					begin
						nxt_acked = ~s2_ff[1];
						// code byte 00001xxx switches to hs rate
						if (byte_ff[7:3] == `HS_CODE_TOP)
							nxt_hs = 1'b1;
					end
					if (bit_ff > 5'h08 && bit_ff < 5'h11)
						nxt_rdata = {rdata_ff[6:0], s2_ff[1]};
					nxt_scl_oe = 1'b1;
					if (bit_ff == (read_ff ? 5'h11 : 5'h08))
						nxt_state = stop_ff ? M_STP1 : M_HOLD;
					else
					begin
						nxt_bit = bit_ff + 5'h01;
						nxt_state = M_LO;
					end
					nxt_done = !stop_ff && bit_ff == (read_ff ? 5'h11 : 5'h08);
				end
			end
			M_STP1:
			begin
				nxt_sda_oe = 1'b1;
				if (tick)
				begin
					nxt_scl_oe = 1'b0;
					nxt_state = M_STP2;
				end
			end
			M_STP2:
				if (tick)
				begin
					nxt_sda_oe = 1'b0;
					nxt_hs = 1'b0;
					nxt_state = M_STP3;
				end
			M_STP3:
				if (tick)
				begin
					nxt_done = 1'b1;
					nxt_state = M_IDLE;
				end
			default:
				nxt_state = M_IDLE;
		endcase
		nxt_ready = (nxt_state == M_IDLE || nxt_state == M_HOLD) && !(i_cmd_valid && ready_ff);
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s1_ff <= 2'h3;
			s2_ff <= 2'h3;
			state_ff <= hs_i2c_pkg::M_IDLE;
			div_ff <= 8'h00;
			bit_ff <= 5'h00;
			byte_ff <= 8'h00;
			read_ff <= 1'b0;
			stop_ff <= 1'b0;
			hs_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			done_ff <= 1'b0;
			acked_ff <= 1'b0;
			rdata_ff <= 8'h00;
			ready_ff <= 1'b0;
		end
		else
		begin
			s1_ff <= {bus.sda, bus.scl};
			s2_ff <= s1_ff;
			state_ff <= nxt_state;
			div_ff <= nxt_div;
			bit_ff <= nxt_bit;
			byte_ff <= nxt_byte;
			read_ff <= nxt_read;
			stop_ff <= nxt_stop;
			hs_ff <= nxt_hs;
			scl_oe_ff <= nxt_scl_oe;
			sda_oe_ff <= nxt_sda_oe;
			done_ff <= nxt_done;
			acked_ff <= nxt_acked;
			rdata_ff <= nxt_rdata;
			ready_ff <= nxt_ready;
		end
	end

	assign o_cmd_ready = ready_ff;
	assign o_done = done_ff;
	assign o_acked = acked_ff;
	assign o_rdata = rdata_ff;
	assign o_hs_mode = hs_ff;
	assign bus.m_scl_out = 1'b0;
	assign bus.m_sda_out = 1'b0;
	assign bus.m_scl_oe = scl_oe_ff;
	assign bus.m_sda_oe = sda_oe_ff;
endmodule // hs_i2c_master

// *** verification/hs_i2c_link_properties.sv ***
// concurrent checks on the open-drain link between master and alert slave
`timescale 1ns/1ps
`include "hs_i2c_consts.svh"
module hs_i2c_link_properties #(
	parameter int TIMEOUT_CYC = 2000
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic alert_n,
	input wire logic s_sda_oe
);
	localparam logic [7:0] ARA_RD = {`ARA_ADDR, 1'b1};
	localparam logic [7:0] ARA_WR = {`ARA_ADDR, 1'b0};
	logic scl_q_ff, sda_q_ff, quiet_ff, nxt_quiet, scl_rise, frame_edge, ninth;
	logic [3:0] bit_cnt_ff, nxt_bit_cnt;
	logic [7:0] shift_ff, nxt_shift, byte1_ff, nxt_byte1;
	logic [15:0] idle_cnt_ff, nxt_idle_cnt;
	// ==========================================
	// bit tracking
	always_comb
	begin
		scl_rise = scl & ~scl_q_ff;
		frame_edge = scl & scl_q_ff & (sda != sda_q_ff);
		ninth = scl_rise & (bit_cnt_ff == 4'h8);
		nxt_bit_cnt = bit_cnt_ff;
		nxt_shift = shift_ff;
		nxt_byte1 = byte1_ff;
		nxt_quiet = quiet_ff;
		nxt_idle_cnt = (idle_cnt_ff == 16'hffff) ? idle_cnt_ff : idle_cnt_ff + 16'h0001;
		if (scl != scl_q_ff)
			nxt_idle_cnt = 16'h0000;
		if (frame_edge)
		begin
			nxt_bit_cnt = 4'h0;
			nxt_quiet = 1'b0;
		end
		else if (scl_rise)
		begin
			nxt_bit_cnt = (bit_cnt_ff == 4'hf) ? bit_cnt_ff : bit_cnt_ff + 4'h1;
			nxt_shift = {shift_ff[6:0], sda};
			if (bit_cnt_ff == 4'h7)
				nxt_byte1 = {shift_ff[6:0], sda};
			if (ninth && byte1_ff == ARA_RD && alert_n)
				nxt_quiet = 1'b1;
		end
	end
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
			quiet_ff <= 1'b0;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			byte1_ff <= 8'h00;
			idle_cnt_ff <= 16'h0000;
		end
		else
		begin
			scl_q_ff <= scl;
			sda_q_ff <= sda;
			quiet_ff <= nxt_quiet;
			bit_cnt_ff <= nxt_bit_cnt;
			shift_ff <= nxt_shift;
			byte1_ff <= nxt_byte1;
			idle_cnt_ff <= nxt_idle_cnt;
		end
	end
	// ==========================================
	// assertions
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	a_drive_rise_low: assert property ($rose(s_sda_oe) |-> !scl)
		else $error("slave took sda while scl high");
	a_release_scl_low: assert property ($fell(s_sda_oe) |-> !scl && !$past(scl))
		else $error("slave released sda near scl high");
	a_code_nack: assert property (ninth && (byte1_ff[7:3] == `HS_CODE_TOP
		|| byte1_ff == ARA_WR) |-> sda)
		else $error("code or alert write byte acked");
	a_ara_ack: assert property (ninth && byte1_ff == ARA_RD |-> sda == alert_n)
		else $error("alert response ack wrong");
	a_ara_quiet: assert property (quiet_ff |-> !s_sda_oe)
		else $error("slave drove sda with no alert");
	a_ara_addr_top: assert property (scl_rise && byte1_ff == ARA_RD && !quiet_ff
		&& bit_cnt_ff inside {4'h9, 4'ha, 4'hb} |-> sda == (bit_cnt_ff == 4'h9))
		else $error("reported address top bits wrong");
	a_timeout_free: assert property (idle_cnt_ff > TIMEOUT_CYC + 20 |-> !s_sda_oe)
		else $error("sda held past timeout");
	a_alert_steady: assert property (ninth && byte1_ff == ARA_RD && !alert_n
		|=> !alert_n [*8])
		else $error("alert dropped during response");
	c_ara_ack: cover property (ninth && byte1_ff == ARA_RD && !sda);
	c_hs_code: cover property (ninth && byte1_ff[7:3] == `HS_CODE_TOP);
	c_timeout: cover property (idle_cnt_ff > TIMEOUT_CYC && !scl);
endmodule // hs_i2c_link_properties

// *** verification/tb_top.sv ***
// self-checking bench for the hs i2c master and alert slave pair
`timescale 1ns/1ps
`include "hs_i2c_consts.svh"
module tb_top;
	localparam int TOUT = 2000;
	localparam logic [7:0] ARA_RD = {`ARA_ADDR, 1'b1};
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic cmd_valid = 1'b0;
	logic [7:0] cmd_byte = 8'h00;
	logic cmd_read = 1'b0;
	logic cmd_stop = 1'b0;
	logic alert_pending = 1'b1;
	hs_i2c_pkg::sel_code_t sel_lo = hs_i2c_pkg::SEL_GND;
	hs_i2c_pkg::sel_code_t sel_hi = hs_i2c_pkg::SEL_GND;
	logic pin_lo, pin_hi, cmd_ready, done, acked, m_hs, s_hs, ara_won, tout;
	logic [7:0] rdata;
	logic [6:0] own_addr;
	int compares = 0, miscompares = 0, cycles = 0, won_cnt = 0, tout_cnt = 0;
	hs_i2c_bus_if u_hs_i2c_bus_if ();
	function automatic logic strap(input hs_i2c_pkg::sel_code_t s, input logic d, input logic c);
		return s[1] ? (s[0] ? c : d) : s[0];
	endfunction
	assign pin_lo = strap(sel_lo, u_hs_i2c_bus_if.sda, u_hs_i2c_bus_if.scl);
	assign pin_hi = strap(sel_hi, u_hs_i2c_bus_if.sda, u_hs_i2c_bus_if.scl);
	hs_i2c_master #(.FS_HALF(40), .HS_HALF(12)) u_hs_i2c_master (.i_ref_clk(i_ref_clk),
		.i_rst(i_rst), .i_cmd_valid(cmd_valid), .i_cmd_byte(cmd_byte), .i_cmd_read(cmd_read),
		.i_cmd_stop(cmd_stop), .o_cmd_ready(cmd_ready), .o_done(done), .o_acked(acked),
		.o_rdata(rdata), .o_hs_mode(m_hs), .bus(u_hs_i2c_bus_if.master));
	hs_i2c_slave #(.TIMEOUT_CYC(TOUT)) u_hs_i2c_slave (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_addr_select_low_pin(pin_lo), .i_addr_select_high_pin(pin_hi),
		.i_alert_pending(alert_pending), .o_hs_mode(s_hs), .o_own_addr(own_addr),
		.o_ara_won(ara_won), .o_timeout(tout), .bus(u_hs_i2c_bus_if.slave));
	hs_i2c_link_properties #(.TIMEOUT_CYC(TOUT)) u_hs_i2c_link_properties (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .scl(u_hs_i2c_bus_if.scl),
		.sda(u_hs_i2c_bus_if.sda), .alert_n(u_hs_i2c_bus_if.alert_n),
		.s_sda_oe(u_hs_i2c_bus_if.s_sda_oe));
	// ==========================================
	// clock, watchdog, pulse counters
	always #4 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk)
	begin
		cycles++;
		if (ara_won === 1'b1)
			won_cnt++;
		if (tout === 1'b1)
			tout_cnt++;
		if (cycles == 80000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	// ==========================================
	// shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic send(input logic [7:0] b, input logic rd, input logic stp);
		int n;
		n = 0;
		@(posedge i_ref_clk);
		cmd_valid <= 1'b1;
		cmd_byte <= b;
		cmd_read <= rd;
		cmd_stop <= stp;
		do @(negedge i_ref_clk); while (cmd_ready !== 1'b1);
		@(posedge i_ref_clk);
		cmd_valid <= 1'b0;
		do
		begin
			@(negedge i_ref_clk);
			n++;
		end while (done !== 1'b1 && n < 8000);
		if (n == 8000)
		begin
			miscompares++;
			report_and_stop();
		end
	endtask
	task automatic set_straps(input int i, input logic pend);
		@(posedge i_ref_clk);
		sel_hi <= hs_i2c_pkg::sel_code_t'(i[3:2]);
		sel_lo <= hs_i2c_pkg::sel_code_t'(i[1:0]);
		alert_pending <= pend;
		repeat (4) @(posedge i_ref_clk);
	endtask
	// ==========================================
	// scenarios
	task automatic t_sweep();
		int w;
		for (int i = 0; i < 16; i++)
		begin
			set_straps(i, 1'b1);
			w = won_cnt;
			check(8'(u_hs_i2c_bus_if.alert_n), 8'h00);
			send(ARA_RD, 1'b1, 1'b1);
			check(8'(acked), 8'h01);
			check(rdata, {`SLV_ADDR_TOP, 4'(i), 1'b0});
			check(8'(won_cnt - w), 8'h01);
		end
	endtask
	task automatic t_refuse();
		int w;
		send({`ARA_ADDR, 1'b0}, 1'b0, 1'b1);
		check(8'(acked), 8'h00);
		set_straps(5, 1'b0);
		check(8'(u_hs_i2c_bus_if.alert_n), 8'h01);
		w = won_cnt;
		send(ARA_RD, 1'b1, 1'b1);
		check(8'(acked), 8'h00);
		check(8'(won_cnt - w), 8'h00);
		check(rdata, 8'hff);
	endtask
	task automatic t_hs();
		set_straps(5, 1'b1);
		for (int k = 0; k < 8; k++)
		begin
			send({`HS_CODE_TOP, 3'(k)}, 1'b0, 1'b0);
			check(8'(acked), 8'h00);
			repeat (16) @(negedge i_ref_clk);
			check({6'h00, m_hs, s_hs}, 8'h03);
			send(ARA_RD, 1'b1, 1'b0);
			check(rdata, {7'h45, 1'b0});
			check(8'(s_hs), 8'h01);
			send(ARA_RD, 1'b1, 1'b1);
			repeat (8) @(posedge i_ref_clk);
			check({6'h00, m_hs, s_hs}, 8'h00);
		end
	endtask
	task automatic t_timeout();
		int n;
		int t;
		set_straps(10, 1'b1);
		send({7'h4a, 1'b0}, 1'b0, 1'b0);
		check(8'(acked), 8'h01);
		check(8'(own_addr), 8'h4a);
		n = 0;
		t = tout_cnt;
		do
		begin
			@(negedge i_ref_clk);
			n++;
		end while (tout_cnt == t && n < 3000);
		check(8'(n >= TOUT - 20 && n <= TOUT + 60), 8'h01);
		send(ARA_RD, 1'b1, 1'b1);
		check(rdata, {7'h4a, 1'b0});
	endtask
	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		t_sweep();
		t_refuse();
		t_hs();
		t_timeout();
		report_and_stop();
	end
endmodule // tb_top
